//--- verilog/fccm_defines.vh
// Constants for the FPGA chain configuration master: register map,
// field positions, reset values and timing counts.
// Assumes a 25 MHz clock and a classic Wishbone slave with 32-bit data.
// Operation
// - Start reconfiguration by driving the active-low program line low.
// - Slave serial: pulse program line first, then shift data into chain.
// - While shifting, watch both done and init lines continuously.
// - Done high means success; chain then initialises and awaits commands.
// - Checksum stored flash data before any reprogramming is triggered.
// - Bootloader image always sits at flash address zero.
// - At power-up or restart, boot from the image at flash address zero.
// - After boot copy code to SDRAM, then reprogram from operational sector.
// - Every stored image starts on a sector boundary.
// - JTAG mode drives TMS and TCK, feeds TDI, counts bits, flags done.
`ifndef FCCM_DEFINES_VH
`define FCCM_DEFINES_VH

`define FCCM_REG_CTRL 8'h00
`define FCCM_REG_STAT 8'h04
`define FCCM_REG_IRQ 8'h08
`define FCCM_REG_MASK 8'h0C
`define FCCM_REG_DATA 8'h10
`define FCCM_REG_BITS 8'h14
`define FCCM_REG_CSUM 8'h18
`define FCCM_REG_FADDR 8'h1C
`define FCCM_REG_BOOT 8'h20

// Control register fields
`define FCCM_CTRL_START 0
`define FCCM_CTRL_JTAG 1
`define FCCM_CTRL_ABORT 2
`define FCCM_CTRL_CSUM_CLR 3
`define FCCM_CTRL_BOOTREQ 4

// Interrupt bits
`define FCCM_IRQ_DONE 0
`define FCCM_IRQ_ERR 1
`define FCCM_IRQ_WREQ 2
`define FCCM_IRQ_BOOT 3
`define FCCM_IRQ_W 4

`define FCCM_BOOT_ADDR 32'h0000_0000
`define FCCM_SECTOR_MASK 32'h0000_FFFF
`define FCCM_OP_SECTOR 32'h0001_0000

// Program pulse low time, ns, and serial clock divider
`define FCCM_CLK_MHZ 25
`define FCCM_PROG_NS 500
`define FCCM_PROG_CYC ((`FCCM_PROG_NS * `FCCM_CLK_MHZ + 999) / 1000)
`define FCCM_DIV 4

`endif

//--- verilog/fccm_top.v
// FPGA chain configuration master: slave-serial and JTAG loaders with
// Wishbone registers, word checksum and boot image address tracking.
// Assumes a single 25 MHz clock; chain pins are synchronous inputs.
`include "fccm_defines.vh"

module fccm_top (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Byte address
  input wire [3:0] wb_sel_i, // Byte selects
  input wire [31:0] wb_dat_i, // Write data
  output reg [31:0] wb_dat_o, // Read data
  output reg wb_ack_o, // Acknowledge
  output reg irq_o, // Level interrupt
  output reg config_program_n, // Chain program line, active low
  output reg cfg_cclk, // Serial configuration clock
  output reg cfg_din, // Serial data to first device
  input wire cfg_done, // Chain done
  input wire cfg_init_n, // Chain init, active low
  output reg jtag_tck, // JTAG clock
  output reg jtag_tms, // JTAG mode select
  output reg jtag_tdi, // JTAG data in
  output reg boot_flash_addr_valid, // Boot address request
  output reg [31:0] boot_flash_addr // Flash address to boot from
);

  localparam ST_IDLE = 3'd0;
  localparam ST_PROG = 3'd1;
  localparam ST_WINIT = 3'd2;
  localparam ST_SHIFT = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_WDONE = 3'd5;
  localparam ST_JTAG = 3'd6;

  localparam integer PROG_CYC_I = `FCCM_PROG_CYC;
  localparam integer DIV_LAST_I = `FCCM_DIV - 1;
  localparam [7:0] PROG_CYC = PROG_CYC_I[7:0];
  localparam [1:0] DIV_LAST = DIV_LAST_I[1:0];

  function [31:0] sel_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      sel_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) sel_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  reg [2:0] state_ff;
  reg [7:0] cnt_ff;
  reg [1:0] div_ff;
  reg [31:0] data_ff;
  reg [5:0] bitn_ff;
  reg data_vld_ff;
  reg jtag_mode_ff;
  reg [31:0] bits_ff;
  reg [31:0] csum_ff;
  reg [31:0] faddr_ff;
  reg [`FCCM_IRQ_W-1:0] irq_st_ff;
  reg [`FCCM_IRQ_W-1:0] irq_mask_ff;
  reg done_ok_ff;
  reg err_ff;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire wr_ctrl = wb_wr & (wb_adr_i == `FCCM_REG_CTRL);
  wire wr_data = wb_wr & (wb_adr_i == `FCCM_REG_DATA);
  wire div_tick = (div_ff == DIV_LAST);
  wire busy = (state_ff != ST_IDLE);
  wire start = wr_ctrl & wb_sel_i[0] & wb_dat_i[`FCCM_CTRL_START] & ~busy;
  wire abort = wr_ctrl & wb_sel_i[0] & wb_dat_i[`FCCM_CTRL_ABORT];
  wire sector_ok = ((wb_dat_i & `FCCM_SECTOR_MASK) == 32'h0000_0000);

  // Registered events: status picks them up one cycle later, race free
  reg [`FCCM_IRQ_W-1:0] ev_ff;

  // Divider: ticks every fourth clock; serial clocks toggle per tick, an eighth of the system clock
  always @(posedge clk) begin
    if (rst) div_ff <= 2'd0;
    else div_ff <= div_ff + 2'd1;
  end

  // Loader state machine
  always @(posedge clk) begin
    ev_ff <= {`FCCM_IRQ_W{1'b0}};
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      config_program_n <= 1'b1;
      cfg_cclk <= 1'b0;
      cfg_din <= 1'b0;
      jtag_tck <= 1'b0;
      jtag_tms <= 1'b1;
      jtag_tdi <= 1'b0;
      data_ff <= 32'h0000_0000;
      bitn_ff <= 6'd0;
      data_vld_ff <= 1'b0;
      jtag_mode_ff <= 1'b0;
      bits_ff <= 32'h0000_0000;
      done_ok_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      if (wr_data && !data_vld_ff) begin
        data_ff <= sel_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
        data_vld_ff <= 1'b1;
      end
      if (abort) begin
        state_ff <= ST_IDLE;
        config_program_n <= 1'b1;
        cfg_cclk <= 1'b0;
        jtag_tck <= 1'b0;
        data_vld_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (start) begin
              jtag_mode_ff <= wb_dat_i[`FCCM_CTRL_JTAG];
              bits_ff <= 32'h0000_0000;
              done_ok_ff <= 1'b0;
              err_ff <= 1'b0;
              cnt_ff <= 8'h00;
              if (wb_dat_i[`FCCM_CTRL_JTAG]) begin
                state_ff <= ST_WDATA;
              end else begin
                config_program_n <= 1'b0;
                state_ff <= ST_PROG;
              end
            end
          end
          ST_PROG: begin
            cnt_ff <= cnt_ff + 8'd1;
            if (cnt_ff >= PROG_CYC - 8'd1) begin
              config_program_n <= 1'b1;
              state_ff <= ST_WINIT;
            end
          end
          ST_WINIT: begin
            if (cfg_init_n) begin
              state_ff <= ST_WDATA;
              ev_ff[`FCCM_IRQ_WREQ] <= 1'b1;
            end
          end
          ST_WDATA: begin
            if (!jtag_mode_ff && cfg_done) begin
              state_ff <= ST_WDONE;
            end else if (!jtag_mode_ff && !cfg_init_n) begin
              err_ff <= 1'b1;
              ev_ff[`FCCM_IRQ_ERR] <= 1'b1;
              state_ff <= ST_IDLE;
            end else if (data_vld_ff && div_tick) begin
              bitn_ff <= 6'd0;
              // First bit settles a full tick before the clock rises
              cfg_din <= data_ff[31];
              state_ff <= jtag_mode_ff ? ST_JTAG : ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (cfg_done) begin
              cfg_cclk <= 1'b0;
              state_ff <= ST_WDONE;
            end else if (!cfg_init_n) begin
              cfg_cclk <= 1'b0;
              err_ff <= 1'b1;
              data_vld_ff <= 1'b0;
              ev_ff[`FCCM_IRQ_ERR] <= 1'b1;
              state_ff <= ST_IDLE;
            end else if (div_tick) begin
              if (!cfg_cclk) begin
                if (bitn_ff == 6'd32) begin
                  data_vld_ff <= 1'b0;
                  ev_ff[`FCCM_IRQ_WREQ] <= 1'b1;
                  state_ff <= ST_WDATA;
                end else begin
                  cfg_cclk <= 1'b1;
                  // Counted at the rising edge: done may end the load here
                  bits_ff <= bits_ff + 32'd1;
                end
              end else begin
                cfg_cclk <= 1'b0;
                bitn_ff <= bitn_ff + 6'd1;
                // Next bit moves only while the clock is low
                cfg_din <= data_ff[5'd30 - bitn_ff[4:0]];
              end
            end
          end
          ST_WDONE: begin
            done_ok_ff <= 1'b1;
            ev_ff[`FCCM_IRQ_DONE] <= 1'b1;
            data_vld_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
          ST_JTAG: begin
            if (div_tick) begin
              if (!jtag_tck) begin
                if (bitn_ff == 6'd16) begin
                  data_vld_ff <= 1'b0;
                  // Data word bit 0, the last TDI bit, marks the last vector
                  if (data_ff[0]) begin
                    done_ok_ff <= 1'b1;
                    ev_ff[`FCCM_IRQ_DONE] <= 1'b1;
                    state_ff <= ST_IDLE;
                  end else begin
                    ev_ff[`FCCM_IRQ_WREQ] <= 1'b1;
                    state_ff <= ST_WDATA;
                  end
                end else begin
                  // Word pairs: TMS from bit 31-n, TDI from bit 15-n
                  jtag_tms <= data_ff[31 - bitn_ff[3:0]];
                  jtag_tdi <= data_ff[15 - bitn_ff[3:0]];
                  jtag_tck <= 1'b1;
                end
              end else begin
                jtag_tck <= 1'b0;
                bitn_ff <= bitn_ff + 6'd1;
                bits_ff <= bits_ff + 32'd1;
              end
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // Checksum of flash-bound words, boot address control
  reg [`FCCM_IRQ_W-1:0] ev2_ff;
  always @(posedge clk) begin
    ev2_ff <= {`FCCM_IRQ_W{1'b0}};
    if (rst) begin
      csum_ff <= 32'h0000_0000;
      faddr_ff <= `FCCM_OP_SECTOR;
      boot_flash_addr <= `FCCM_BOOT_ADDR;
      boot_flash_addr_valid <= 1'b1;
    end else begin
      boot_flash_addr_valid <= 1'b0;
      if (wb_wr && wb_adr_i == `FCCM_REG_CSUM) begin
        csum_ff <= csum_ff + wb_dat_i;
      end else if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`FCCM_CTRL_CSUM_CLR]) begin
        csum_ff <= 32'h0000_0000;
      end
      if (wb_wr && wb_adr_i == `FCCM_REG_FADDR && sector_ok &&
          wb_dat_i != `FCCM_BOOT_ADDR) begin
        faddr_ff <= wb_dat_i;
      end
      if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`FCCM_CTRL_BOOTREQ]) begin
        boot_flash_addr <= faddr_ff;
        boot_flash_addr_valid <= 1'b1;
        ev2_ff[`FCCM_IRQ_BOOT] <= 1'b1;
      end
    end
  end

  // Status, mask, interrupt and bus answer
  always @(posedge clk) begin
    if (rst) begin
      irq_st_ff <= {`FCCM_IRQ_W{1'b0}};
      irq_mask_ff <= {`FCCM_IRQ_W{1'b0}};
      irq_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      // Set wins over write-one-to-clear
      if (wb_wr && wb_adr_i == `FCCM_REG_IRQ && wb_sel_i[0])
        irq_st_ff <= (irq_st_ff & ~wb_dat_i[`FCCM_IRQ_W-1:0]) | ev_ff |
          ev2_ff;
      else
        irq_st_ff <= irq_st_ff | ev_ff | ev2_ff;
      if (wb_wr && wb_adr_i == `FCCM_REG_MASK && wb_sel_i[0])
        irq_mask_ff <= wb_dat_i[`FCCM_IRQ_W-1:0];
      irq_o <= |(irq_st_ff & irq_mask_ff);
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `FCCM_REG_CTRL: wb_dat_o <= {31'h0000_0000, jtag_mode_ff};
          `FCCM_REG_STAT: wb_dat_o <= {21'h00_0000, data_vld_ff,
            cfg_init_n, cfg_done, config_program_n, err_ff, done_ok_ff,
            busy, 1'b0, state_ff};
          `FCCM_REG_IRQ: wb_dat_o <= {28'h000_0000, irq_st_ff};
          `FCCM_REG_MASK: wb_dat_o <= {28'h000_0000, irq_mask_ff};
          `FCCM_REG_DATA: wb_dat_o <= data_ff;
          `FCCM_REG_BITS: wb_dat_o <= bits_ff;
          `FCCM_REG_CSUM: wb_dat_o <= csum_ff;
          `FCCM_REG_FADDR: wb_dat_o <= faddr_ff;
          `FCCM_REG_BOOT: wb_dat_o <= boot_flash_addr;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // fccm_top

//--- verification/fccm_chain_model.sv
// Behavioural model of the downstream slave-serial device chain.
// Assumes cclk far slower than clk; fault holds init low on demand.
module fccm_chain_model #(parameter int NBITS = 64) (
  input wire logic clk, // Clock
  input wire logic prog_n, // Program line, active low
  input wire logic cclk, // Serial clock
  input wire logic din, // Serial data
  input wire logic fault, // Force an init error
  output logic done = 1'b0, // Chain configured
  output logic init_n = 1'b1, // Init line, active low
  output logic [31:0] word = 32'h0000_0000 // Last 32 bits taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cclk_q = 1'b0;
  int cnt = 0;
  int hold = 0;
  always @(posedge clk) begin
    cclk_q <= cclk;
    if (!prog_n) begin
      {done, init_n} <= 2'b00;
      cnt <= 0;
      hold <= 6;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      init_n <= !fault;
      if (cclk && !cclk_q) begin
        word <= {word[30:0], din};
        cnt <= cnt + 1;
        done <= done || cnt + 1 == NBITS;
      end
    end
  end
endmodule // fccm_chain_model

//--- verification/fccm_top_chk.sv
// Checker for the configuration master pins and bus handshake.
// Bound into every fccm_top; sees its ports only.
module fccm_top_chk (
  input wire clk, // Clock
  input wire rst, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_ack_o, // Acknowledge
  input wire config_program_n, // Program line
  input wire cfg_cclk, // Serial clock
  input wire cfg_din, // Serial data
  input wire cfg_done, // Done pin
  input wire cfg_init_n, // Init pin
  input wire jtag_tck, // JTAG clock
  input wire jtag_tms, // JTAG mode
  input wire boot_flash_addr_valid, // Boot request
  input wire [31:0] boot_flash_addr // Boot address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_cnt_ff;
  always @(posedge clk) begin
    if (rst || config_program_n) low_cnt_ff <= 5'h00;
    else low_cnt_ff <= low_cnt_ff + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_one_cycle_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_latency_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
  prog_width_a:
    assert property ($rose(config_program_n) |-> low_cnt_ff == 5'h0d)
      else $error("program pulse width wrong");
  prog_before_data_a:
    assert property (!config_program_n |-> !cfg_cclk)
      else $error("clock during program pulse");
  din_stable_a:
    assert property (cfg_cclk |-> $stable(cfg_din))
      else $error("data moved while clock high");
  init_gate_a:
    assert property ($rose(cfg_cclk) |-> cfg_init_n && config_program_n)
      else $error("shift before init high");
  done_stops_a:
    assert property ($rose(cfg_done) |-> ##[1:6] !cfg_cclk [*8])
      else $error("shifting after done");
  init_err_stops_a:
    assert property ($fell(cfg_init_n) && config_program_n
      |-> ##[1:6] !cfg_cclk [*8]) else $error("shifting after init error");
  jtag_idle_a:
    assert property (!config_program_n |-> jtag_tms && !jtag_tck)
      else $error("jtag busy in serial load");
  boot_sector_a:
    assert property (boot_flash_addr_valid |-> boot_flash_addr[15:0] == 0)
      else $error("boot address off sector");
endmodule // fccm_top_chk
bind fccm_top fccm_top_chk fccm_top_chk_inst (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .config_program_n, .cfg_cclk, .cfg_din, .cfg_done,
  .cfg_init_n, .jtag_tck, .jtag_tms, .boot_flash_addr_valid,
  .boot_flash_addr);

//--- verification/test_fccm_top.sv
// Self-checking bench for the chain configuration master.
// Classic Wishbone master tasks; the chain model answers the pins.
`include "fccm_defines.vh"
module test_fccm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fault = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, q, word;
  wire [31:0] rdat, baddr;
  wire ack, irq, prog_n, cclk, din, done, init_n, tck, tms, tdi, bval;
  int fail_count = 0, check_count = 0, cycles = 0;
  fccm_top fccm_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .config_program_n(prog_n), .cfg_cclk(cclk), .cfg_din(din),
    .cfg_done(done), .cfg_init_n(init_n), .jtag_tck(tck), .jtag_tms(tms),
    .jtag_tdi(tdi), .boot_flash_addr_valid(bval), .boot_flash_addr(baddr));
  fccm_chain_model fccm_chain_model_inst (.clk(clk), .prog_n(prog_n),
    .cclk(cclk), .din(din), .fault(fault), .done(done), .init_n(init_n),
    .word(word));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask
  // Polls one event bit, then clears it with a one
  task automatic wirq(input int b);
    repeat (400) begin
      wb(1'b0, `FCCM_REG_IRQ, 32'h0000_0000);
      if (q[b] === 1'b1) break;
    end
    chk({31'h0, q[b]}, 32'h0000_0001);
    wb(1'b1, `FCCM_REG_IRQ, 32'h0000_0001 << b);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`FCCM_REG_STAT, 32'h0000_00f0, 32'h0000_0080);
    rd(`FCCM_REG_BOOT, 32'hffff_ffff, `FCCM_BOOT_ADDR);
    rd(8'h3c, 32'hffff_ffff, 32'h0000_0000);
    wb(1'b1, `FCCM_REG_FADDR, 32'h0001_2345);
    wb(1'b1, `FCCM_REG_FADDR, 32'h0000_0000);
    rd(`FCCM_REG_FADDR, 32'hffff_ffff, 32'h0001_0000);
    wb(1'b1, `FCCM_REG_FADDR, 32'h0002_0000);
    wb(1'b1, `FCCM_REG_CTRL, 32'h0000_0010);
    wirq(`FCCM_IRQ_BOOT);
    chk(baddr, 32'h0002_0000);
    wb(1'b1, `FCCM_REG_CTRL, 32'h0000_0008);
    wb(1'b1, `FCCM_REG_CSUM, 32'h8000_0001);
    wb(1'b1, `FCCM_REG_CSUM, 32'h8000_0003);
    rd(`FCCM_REG_CSUM, 32'hffff_ffff, 32'h0000_0004);
    wb(1'b1, `FCCM_REG_MASK, 32'h0000_000f);
    wb(1'b1, `FCCM_REG_CTRL, 32'h0000_0001);
    wirq(`FCCM_IRQ_WREQ);
    wb(1'b1, `FCCM_REG_DATA, 32'ha5c3_0f96);
    wirq(`FCCM_IRQ_WREQ);
    chk(word, 32'ha5c3_0f96);
    wb(1'b1, `FCCM_REG_DATA, 32'h3c5a_e107);
    wirq(`FCCM_IRQ_DONE);
    chk(word, 32'h3c5a_e107);
    rd(`FCCM_REG_STAT, 32'h0000_0070, 32'h0000_0020);
    rd(`FCCM_REG_BITS, 32'hffff_ffff, 32'h0000_0040);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b1, `FCCM_REG_CTRL, 32'h0000_0001);
    wirq(`FCCM_IRQ_WREQ);
    wb(1'b1, `FCCM_REG_MASK, 32'h0000_0000);
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`FCCM_REG_IRQ, 32'h0000_0002, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b1, `FCCM_REG_MASK, 32'h0000_0002);
    rd(`FCCM_REG_STAT, 32'h0000_0060, 32'h0000_0040);
    chk({31'h0, irq}, 32'h0000_0001);
    wirq(`FCCM_IRQ_ERR);
    fault <= 1'b0;
    rd(`FCCM_REG_IRQ, 32'h0000_000f, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b1, `FCCM_REG_CTRL, 32'h0000_0003);
    wb(1'b1, `FCCM_REG_DATA, 32'h1234_0001);
    wirq(`FCCM_IRQ_DONE);
    rd(`FCCM_REG_BITS, 32'hffff_ffff, 32'h0000_0010);
    give_verdict();
  end
endmodule // test_fccm_top
